// file: sbwe_pkg.sv
// shared constants, lane states and drive helpers for the wide extension
// assumes both ends run on the one secondary bus clock
`default_nettype none
package sbwe_pkg;
	localparam int SBWE_AD_W = 32;
	localparam int SBWE_CBE_W = 4;
	localparam int SBWE_CAP_W = SBWE_AD_W + SBWE_CBE_W;
	localparam logic [SBWE_AD_W-1:0] SBWE_AD_PARK = 32'h0000_0000;
	localparam logic [SBWE_CBE_W-1:0] SBWE_CBE_PARK = 4'h0;
	localparam logic [SBWE_CBE_W-1:0] SBWE_BE_NONE = 4'hf;
	localparam logic [1:0] SBWE_PIN_LOW = 2'h2;
	localparam logic [1:0] SBWE_PIN_HIGH = 2'h3;
	localparam logic [1:0] SBWE_PIN_OFF = 2'h0;

	typedef enum logic [1:0]
	{
		SBWE_LN_RST = 2'b00,
		SBWE_LN_TRI = 2'b01,
		SBWE_LN_DRV = 2'b10,
		SBWE_LN_PARK = 2'b11
	} sbwe_lane_t;

	// even parity: the 37 bits together hold an even count of ones
	function automatic logic sbwe_par36(input logic [SBWE_AD_W-1:0] ad, input logic [SBWE_CBE_W-1:0] cbe);
		return ^{ad, cbe};
	endfunction : sbwe_par36

	// active-low sustained pin: low while active, high one clock, then off
	// returns {output enable, output level}
	function automatic logic [1:0] sbwe_sts_drive(input logic was_act, input logic now_act);
		logic [1:0] r;
		r = SBWE_PIN_OFF;
		if (now_act)
		begin
			r = SBWE_PIN_LOW;
		end
		else if (was_act)
		begin
			r = SBWE_PIN_HIGH;
		end
		return r;
	endfunction : sbwe_sts_drive
endpackage : sbwe_pkg
`default_nettype wire

// file: sbwe_if.sv
// the upper lanes, upper parity, frame and wide handshake pins of the bus
// assumes undriven pins rest high through external pull-ups
`default_nettype none
interface sbwe_if;
	import sbwe_pkg::*;
	logic [SBWE_AD_W-1:0] dev_ad_o, far_ad_o, ad_hi;
	logic [SBWE_CBE_W-1:0] dev_cbe_o, far_cbe_o, cbe_hi;
	logic dev_lane_oe, far_lane_oe;
	logic dev_par_o, dev_par_oe, far_par_o, far_par_oe, sec_upper_parity;
	logic dev_frame_o, dev_frame_oe, far_frame_o, far_frame_oe, frame_n;
	logic dev_req_o, dev_req_oe, far_req_o, far_req_oe, sec_wide_request_n;
	logic dev_ack_o, dev_ack_oe, far_ack_o, far_ack_oe, sec_wide_ack_n;

	// pull-up wins when nobody drives
	assign ad_hi = dev_lane_oe ? dev_ad_o : (far_lane_oe ? far_ad_o : '1);
	assign cbe_hi = dev_lane_oe ? dev_cbe_o : (far_lane_oe ? far_cbe_o : '1);
	assign sec_upper_parity = dev_par_oe ? dev_par_o : (far_par_oe ? far_par_o : 1'b1);
	assign frame_n = dev_frame_oe ? dev_frame_o : (far_frame_oe ? far_frame_o : 1'b1);
	assign sec_wide_request_n = dev_req_oe ? dev_req_o : (far_req_oe ? far_req_o : 1'b1);
	assign sec_wide_ack_n = dev_ack_oe ? dev_ack_o : (far_ack_oe ? far_ack_o : 1'b1);

	modport dev
	(
		output dev_ad_o, dev_cbe_o, dev_lane_oe, dev_par_o, dev_par_oe,
		output dev_frame_o, dev_frame_oe, dev_req_o, dev_req_oe, dev_ack_o, dev_ack_oe,
		input ad_hi, cbe_hi, sec_upper_parity, frame_n, sec_wide_request_n, sec_wide_ack_n
	);
	modport far
	(
		output far_ad_o, far_cbe_o, far_lane_oe, far_par_o, far_par_oe,
		output far_frame_o, far_frame_oe, far_req_o, far_req_oe, far_ack_o, far_ack_oe,
		input ad_hi, cbe_hi, sec_upper_parity, frame_n, sec_wide_request_n, sec_wide_ack_n
	);
endinterface : sbwe_if
`default_nettype wire

// file: sbwe_far.sv
// far agent end: an initiator or target elsewhere on the secondary bus
// assumes the extension is present; ext_on tells it the bridge enabled it
`default_nettype none
module sbwe_far
(
	input wire logic clock,
	input wire logic reset,
	input wire logic ext_on,
	input wire logic init_frame,
	input wire logic init_wide,
	input wire logic tgt_ack,
	input wire logic drive_hi,
	input wire logic hi_data,
	input wire logic [sbwe_pkg::SBWE_AD_W-1:0] ad_hi_in,
	input wire logic [sbwe_pkg::SBWE_CBE_W-1:0] cbe_hi_in,
	input wire logic check_en,
	sbwe_if.far bus,
	output logic parity_error
);
	import sbwe_pkg::*;

	typedef struct packed
	{
		logic frame_act;
		logic req_act;
		logic ack_act;
		logic [1:0] frame_pin;
		logic [1:0] req_pin;
		logic [1:0] ack_pin;
		sbwe_lane_t lane;
		logic [SBWE_AD_W-1:0] ad;
		logic [SBWE_CBE_W-1:0] cbe;
		logic par;
		logic par_oe;
		logic chk;
		logic [SBWE_CAP_W-1:0] cap;
		logic perr;
	} sbwe_far_state_t;

	sbwe_far_state_t q, n;
	logic both_wide;

	always_comb
	begin
		n = q;
		n.perr = 1'b0;
		both_wide = ~bus.sec_wide_request_n & ~bus.sec_wide_ack_n;
		n.frame_act = init_frame;
		// width is fixed at frame start so both pins drop together
		n.req_act = init_frame & (q.frame_act ? q.req_act : (init_wide & ext_on));
		n.ack_act = tgt_ack & ext_on;
		n.frame_pin = sbwe_sts_drive(q.frame_act, n.frame_act);
		n.req_pin = sbwe_sts_drive(q.req_act, n.req_act);
		n.ack_pin = sbwe_sts_drive(q.ack_act, n.ack_act);
		n.lane = drive_hi ? SBWE_LN_DRV : SBWE_LN_TRI;
		n.ad = ad_hi_in;
		n.cbe = (hi_data & ~both_wide) ? SBWE_BE_NONE : cbe_hi_in;
		n.par = sbwe_par36(q.ad, q.cbe);
		n.par_oe = (q.lane == SBWE_LN_DRV);
		n.chk = check_en & ext_on;
		if (check_en)
		begin
			n.cap = {bus.ad_hi, bus.cbe_hi};
		end
		if (q.chk)
		begin
			n.perr = sbwe_par36(q.cap[SBWE_CAP_W-1:SBWE_CBE_W], q.cap[SBWE_CBE_W-1:0]) != bus.sec_upper_parity;
		end
		if (reset)
		begin
			n = '0;
		end
	end

	always_ff @(posedge clock)
	begin
		q <= n;
	end

	assign bus.far_ad_o = q.ad;
	assign bus.far_cbe_o = q.cbe;
	assign bus.far_lane_oe = (q.lane == SBWE_LN_DRV);
	assign bus.far_par_o = q.par;
	assign bus.far_par_oe = q.par_oe;
	assign {bus.far_frame_oe, bus.far_frame_o} = q.frame_pin;
	assign {bus.far_req_oe, bus.far_req_o} = q.req_pin;
	assign {bus.far_ack_oe, bus.far_ack_o} = q.ack_pin;
	assign parity_error = q.perr;
endmodule : sbwe_far
`default_nettype wire

// file: sbwe_dev.sv
// bridge end of the secondary 64-bit extension: upper lanes, upper parity,
// wide request and acknowledge, and the enable strap caught during reset
// assumes the 32-bit core feeds frame intent and lane data one clock ahead
// and that reset is the secondary bus reset, held for at least two edges
// and that the far agents share this clock, so bus pins are read without
// synchronisers; limitation: two drivers on the upper lanes go unnoticed
//
// Operation
// - upper parity is even over 36 bits
// - parity valid clock after first address
// - parity valid clock after second address
// - parity valid clock after wide data
// - parity released clock after lanes released
// - receiver checks upper parity in wide transfers
// - low request at reset enables extension
// - central function drives request low in reset
// - wide request follows frame timing exactly
// - deassert: drive high one clock, release
// - disabled extension: park lanes at valid levels
// - upper byte enables only when both wide
`default_nettype none
module sbwe_dev
(
	input wire logic clock,
	input wire logic reset,
	input wire logic central_fn,
	input wire logic init_frame,
	input wire logic init_wide,
	input wire logic tgt_ack,
	input wire logic drive_hi,
	input wire logic hi_data,
	input wire logic [sbwe_pkg::SBWE_AD_W-1:0] ad_hi_in,
	input wire logic [sbwe_pkg::SBWE_CBE_W-1:0] cbe_hi_in,
	input wire logic check_en,
	sbwe_if.dev bus,
	output logic wide_enabled,
	output logic parity_error
);
	import sbwe_pkg::*;

	typedef struct packed
	{
		// strap result and reset tracking
		logic rst_seen;
		logic wide_en;
		// sustained-pin intent and pin images
		logic frame_act;
		logic req_act;
		logic ack_act;
		logic [1:0] frame_pin;
		logic [1:0] req_pin;
		logic [1:0] ack_pin;
		// upper lanes and the parity bit that trails them
		sbwe_lane_t lane;
		logic lane_oe;
		logic [SBWE_AD_W-1:0] ad;
		logic [SBWE_CBE_W-1:0] cbe;
		logic par;
		logic par_oe;
		// receive check
		logic chk;
		logic [SBWE_CAP_W-1:0] cap;
		logic perr;
	} sbwe_dev_state_t;

	sbwe_dev_state_t q, n;
	logic both_wide;
	logic frame_start;

	// lanes and parity bit share one ownership decode
	function automatic logic sbwe_lane_drives(input sbwe_lane_t l);
		return (l == SBWE_LN_DRV) || (l == SBWE_LN_PARK);
	endfunction : sbwe_lane_drives

	always_comb
	begin
		n = q;
		n.perr = 1'b0;
		both_wide = ~bus.sec_wide_request_n & ~bus.sec_wide_ack_n;
		frame_start = init_frame & ~q.frame_act;

		// frame and wide request come from one decision and one flop stage,
		// so their edges cannot drift apart
		n.frame_act = init_frame;
		if (frame_start)
		begin
			n.req_act = init_wide & q.wide_en;
		end
		else
		begin
			n.req_act = init_frame & q.req_act;
		end
		n.ack_act = tgt_ack & q.wide_en;

		n.frame_pin = sbwe_sts_drive(q.frame_act, n.frame_act);
		n.req_pin = sbwe_sts_drive(q.req_act, n.req_act);
		n.ack_pin = sbwe_sts_drive(q.ack_act, n.ack_act);

		// lane ownership for the coming clock
		if (~q.wide_en)
		begin
			n.lane = SBWE_LN_PARK;
		end
		else if (drive_hi)
		begin
			n.lane = SBWE_LN_DRV;
		end
		else
		begin
			n.lane = SBWE_LN_TRI;
		end

		case (n.lane)
			SBWE_LN_DRV:
			begin
				n.ad = ad_hi_in;
				// outside a both-wide data phase no upper byte may be enabled
				n.cbe = (hi_data & ~both_wide) ? SBWE_BE_NONE : cbe_hi_in;
			end
			SBWE_LN_PARK:
			begin
				// released pins rest high on the pull-ups, so drive them to the low park levels
				n.ad = SBWE_AD_PARK;
				n.cbe = SBWE_CBE_PARK;
			end
			SBWE_LN_TRI:
			begin
				// pins float; keep the last word so parity stays defined
				n.ad = q.ad;
				n.cbe = q.cbe;
			end
			default:
			begin
				n.ad = SBWE_AD_PARK;
				n.cbe = SBWE_CBE_PARK;
			end
		endcase
		n.lane_oe = sbwe_lane_drives(n.lane);

		// parity trails the lanes by exactly one clock, in every phase kind
		n.par = sbwe_par36(q.ad, q.cbe);
		// release also trails by one clock; parked lanes keep parity driven
		n.par_oe = sbwe_lane_drives(q.lane);

		// receive side: capture the lanes, compare parity one clock later
		n.chk = check_en & q.wide_en;
		if (check_en)
		begin
			n.cap = {bus.ad_hi, bus.cbe_hi};
		end
		if (q.chk)
		begin
			n.perr = sbwe_par36(q.cap[SBWE_CAP_W-1:SBWE_CBE_W], q.cap[SBWE_CBE_W-1:0]) != bus.sec_upper_parity;
		end

		n.rst_seen = 1'b0;
		if (reset)
		begin
			n = '0;
			n.rst_seen = 1'b1;
			// strap is resampled every reset clock and the last one counts;
			// the first reset clock sees pins still settling, so skip it
			if (q.rst_seen)
			begin
				n.wide_en = ~bus.sec_wide_request_n;
			end
			// bus reset floats every pin of this end but the request
			n.frame_pin = SBWE_PIN_OFF;
			n.ack_pin = SBWE_PIN_OFF;
			n.lane_oe = 1'b0;
			n.par_oe = 1'b0;
			// central function holds the request low all through reset,
			// and the release edge then drives it high for one clock
			n.req_act = central_fn;
			n.req_pin = central_fn ? SBWE_PIN_LOW : SBWE_PIN_OFF;
			n.lane = SBWE_LN_RST;
		end
	end

	always_ff @(posedge clock)
	begin
		q <= n;
	end

	assign bus.dev_ad_o = q.ad;
	assign bus.dev_cbe_o = q.cbe;
	assign bus.dev_lane_oe = q.lane_oe;
	assign bus.dev_par_o = q.par;
	assign bus.dev_par_oe = q.par_oe;
	// pin images are {output enable, level}
	assign bus.dev_frame_oe = q.frame_pin[1];
	assign bus.dev_frame_o = q.frame_pin[0];
	assign bus.dev_req_oe = q.req_pin[1];
	assign bus.dev_req_o = q.req_pin[0];
	assign bus.dev_ack_oe = q.ack_pin[1];
	assign bus.dev_ack_o = q.ack_pin[0];
	assign wide_enabled = q.wide_en;
	assign parity_error = q.perr;
endmodule : sbwe_dev
`default_nettype wire

// file: sbwe_props.sv
// pin checks for the wide extension between the two ends
// assumes interface signals, one clock and a sync reset
`default_nettype none
module sbwe_props
(
	input wire logic clock,
	input wire logic reset,
	input wire logic central_fn,
	input wire logic wide_enabled,
	input wire logic [31:0] ad_hi,
	input wire logic [3:0] cbe_hi,
	input wire logic sec_wide_request_n,
	input wire logic dev_lane_oe,
	input wire logic dev_par_o,
	input wire logic dev_par_oe,
	input wire logic dev_frame_o,
	input wire logic dev_frame_oe,
	input wire logic dev_req_o,
	input wire logic dev_req_oe,
	input wire logic dev_ack_o,
	input wire logic dev_ack_oe,
	input wire logic far_ack_o,
	input wire logic far_ack_oe
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);
	sequence s_req_lo;
		dev_req_oe && !dev_req_o;
	endsequence
	sequence s_req_drop;
		s_req_lo ##1 (!dev_req_oe || dev_req_o);
	endsequence
	sequence s_ack_drop;
		(far_ack_oe && !far_ack_o) ##1 (!far_ack_oe || far_ack_o);
	endsequence
	AST_PAR_EVEN: assert property (dev_lane_oe |=>
		dev_par_oe && dev_par_o == ^{$past(ad_hi), $past(cbe_hi)})
		else $error("upper parity wrong");
	AST_PAR_REL: assert property ($fell(dev_lane_oe) |-> dev_par_oe ##1 !dev_par_oe)
		else $error("upper parity release wrong");
	// the low request left over from central-function reset has no frame
	AST_REQ_FRAME: assert property (dev_req_oe && !dev_req_o && !$past(reset) |->
		dev_frame_oe && !dev_frame_o)
		else $error("wide request without frame");
	AST_REQ_END: assert property (s_req_drop |-> dev_req_oe && dev_req_o ##1 (!dev_req_oe || !dev_req_o))
		else $error("wide request end wrong");
	AST_ACK_END: assert property (s_ack_drop |-> far_ack_oe && far_ack_o ##1 (!far_ack_oe || !far_ack_o))
		else $error("wide ack end wrong");
	// reset-phase rules must not be masked by the reset itself
	AST_REQ_RESET: assert property (disable iff (1'h0) reset && central_fn ##1 reset |-> s_req_lo)
		else $error("request not low in reset");
	AST_STRAP: assert property (disable iff (1'h0) $fell(reset) |->
		wide_enabled == !$past(sec_wide_request_n))
		else $error("strap result wrong");
	AST_QUIET: assert property (!wide_enabled |->
		!(dev_req_oe && !dev_req_o) && !(dev_ack_oe && !dev_ack_o))
		else $error("wide signal while disabled");
	AST_PARK: assert property (!wide_enabled [*3] |->
		dev_lane_oe && dev_par_oe && ad_hi == 32'h0 && cbe_hi == 4'h0)
		else $error("lanes not parked");
endmodule : sbwe_props
`default_nettype wire

// file: tb.sv
// bench: bridge end and far agent face each other on the interface
// assumes the checker sits beside that interface
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 1'h0, reset = 1'h1, cfn = 1'h0, d_fr = 1'h0, d_wd = 1'h0, d_ta = 1'h0;
	logic d_dh = 1'h0, d_hd = 1'h0, f_ack = 1'h0, f_ck = 1'h0, wide_en, d_perr, f_perr;
	logic f_dh = 1'h0, d_ck = 1'h0;
	logic [31:0] d_ad = 32'h0;
	logic [3:0] d_cb = 4'h0;
	int n_errors = 0, checks_done = 0;
	sbwe_if bus();
	always #50 clock = ~clock;
	sbwe_dev sbwe_dev_i
	(
		.clock(clock), .reset(reset), .central_fn(cfn), .init_frame(d_fr), .init_wide(d_wd), .tgt_ack(d_ta),
		.drive_hi(d_dh), .hi_data(d_hd), .ad_hi_in(d_ad), .cbe_hi_in(d_cb), .check_en(d_ck), .bus(bus.dev),
		.wide_enabled(wide_en), .parity_error(d_perr)
	);
	sbwe_far sbwe_far_i
	(
		.clock(clock), .reset(reset), .ext_on(wide_en), .init_frame(1'h0), .init_wide(d_wd), .tgt_ack(f_ack),
		.drive_hi(f_dh), .hi_data(d_hd), .ad_hi_in(d_ad), .cbe_hi_in(d_cb), .check_en(f_ck), .bus(bus.far),
		.parity_error(f_perr)
	);
	sbwe_props sbwe_props_i
	(
		.clock(clock), .reset(reset), .central_fn(cfn), .wide_enabled(wide_en), .ad_hi(bus.ad_hi),
		.cbe_hi(bus.cbe_hi), .sec_wide_request_n(bus.sec_wide_request_n), .dev_lane_oe(bus.dev_lane_oe),
		.dev_par_o(bus.dev_par_o), .dev_par_oe(bus.dev_par_oe), .dev_frame_o(bus.dev_frame_o),
		.dev_frame_oe(bus.dev_frame_oe), .dev_req_o(bus.dev_req_o), .dev_req_oe(bus.dev_req_oe),
		.dev_ack_o(bus.dev_ack_o), .dev_ack_oe(bus.dev_ack_oe), .far_ack_o(bus.far_ack_o),
		.far_ack_oe(bus.far_ack_oe)
	);
	task automatic chk(input string nm, input logic [36:0] e, input logic [36:0] g);
		checks_done++;
		if (g !== e)
		begin
			$display("Error %s expected %h seen %h", nm, e, g);
			n_errors++;
		end
	endtask : chk
	task automatic print_verdict;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : print_verdict
	task automatic do_reset(input logic c);
		@(posedge clock);
		reset <= 1'h1;
		cfn <= c;
		d_fr <= 1'h0;
		repeat (10) @(posedge clock);
		reset <= 1'h0;
		#1;
		chk("wide_en", c, wide_en);
	endtask : do_reset
	// two wide data words back to back, far end as target and receiver
	task automatic s_wide;
		@(posedge clock);
		d_fr <= 1'h1;
		d_wd <= 1'h1;
		f_ack <= 1'h1;
		@(posedge clock);
		d_dh <= 1'h1;
		d_hd <= 1'h1;
		d_ad <= 32'h8000_0001;
		d_cb <= 4'h1;
		#1;
		chk("req_ack", 2'h0, {bus.sec_wide_request_n, bus.sec_wide_ack_n});
		@(posedge clock);
		d_ad <= 32'h0000_00ff;
		d_cb <= 4'h3;
		f_ck <= 1'h1;
		#1;
		chk("lanes", {32'h8000_0001, 4'h1}, {bus.ad_hi, bus.cbe_hi});
		@(posedge clock);
		d_dh <= 1'h0;
		d_hd <= 1'h0;
		#1;
		chk("par0", ^{32'h8000_0001, 4'h1}, bus.sec_upper_parity);
		@(posedge clock);
		d_fr <= 1'h0;
		f_ack <= 1'h0;
		f_ck <= 1'h0;
		#1;
		chk("par1", ^{32'h0000_00ff, 4'h3}, bus.sec_upper_parity);
		@(posedge clock);
		#1;
		chk("par_oe", 1'h0, bus.dev_par_oe);
		chk("req_hi", 2'h3, {bus.dev_req_oe, bus.sec_wide_request_n});
		chk("far_perr", 1'h0, f_perr);
		@(posedge clock);
		#1;
		chk("req_oe", 2'h0, {bus.dev_req_oe, bus.far_ack_oe});
		chk("far_perr", 1'h0, f_perr);
	endtask : s_wide
	// undriven lanes read as all ones against a pulled-up parity bit: bad parity
	task automatic s_perr;
		int hits;
		hits = 0;
		@(posedge clock);
		d_dh <= 1'h1;
		d_hd <= 1'h1;
		@(posedge clock);
		d_dh <= 1'h0;
		d_hd <= 1'h0;
		#1;
		chk("cbe_hi", 4'hf, bus.cbe_hi);
		@(posedge clock);
		f_ck <= 1'h1;
		@(posedge clock);
		f_ck <= 1'h0;
		repeat (5)
		begin
			@(posedge clock);
			#1;
			if (f_perr === 1'h1)
				hits++;
		end
		chk("perr_pulses", 1, hits);
	endtask : s_perr
	// far agent drives a wide word, bridge end receives and checks parity
	task automatic s_rx;
		@(posedge clock);
		f_dh <= 1'h1;
		d_ad <= 32'h1234_5678;
		d_cb <= 4'h5;
		@(posedge clock);
		f_dh <= 1'h0;
		d_ck <= 1'h1;
		@(posedge clock);
		d_ck <= 1'h0;
		#1;
		chk("far_par", ^{32'h1234_5678, 4'h5}, bus.sec_upper_parity);
		@(posedge clock);
		#1;
		chk("dev_perr", 1'h0, d_perr);
	endtask : s_rx
	task automatic s_off;
		@(posedge clock);
		d_fr <= 1'h1;
		d_ta <= 1'h1;
		d_dh <= 1'h1;
		repeat (3) @(posedge clock);
		#1;
		chk("frame_n", 1'h0, bus.frame_n);
		chk("req_ack", 2'h3, {bus.sec_wide_request_n, bus.sec_wide_ack_n});
		chk("park", 37'h0, {bus.ad_hi, bus.cbe_hi, bus.sec_upper_parity});
	endtask : s_off
	initial
	begin
		do_reset(1'h1);
		s_wide();
		s_perr();
		s_rx();
		do_reset(1'h0);
		s_off();
		print_verdict();
	end
endmodule : tb
`default_nettype wire
